// ---- verilog/ebc_bus_ctrl.sv ----
// Behaviour
// R1: rom select low at reset: microcomputer mode, rom in top 16K words.
// R2: rom select high at reset: microprocessor mode, rom addresses external.
// R3: rom select sampled only at reset; mode write may override it later.
// R4: space selects idle high; only accessed space low while address valid.
// R5: space selects float in hold and while output disable is low.
// R6: memory strobe low only for external data or program access.
// R7: io strobe low only for external io access.
// R8: both strobes float in hold and while output disable is low.
// R9: ready low means wait one cycle and sample ready again.
// R10: ready checked only with at least two software wait states.
// R11: ready never sampled before programmed wait states have elapsed.
// R12: outside device holds ready low until it can complete.
// R13: read/write line high, low only during an external write.
// R14: read/write line floats in hold and while output disable is low.
// R15: outside master holds bus request for as long as it needs bus.
// R16: granted request floats address, data, control and asserts acknowledge.
// R17: hold acknowledge driven high throughout reset.
// R18: hold acknowledge floats while output disable is low.
// R19: address lines float in hold and while output disable is low.
// R20: data lines float unless writing, and during reset or bus request.
// R21: running access finishes before hold; release resumes driving the bus.
`timescale 1ns/100ps
`default_nettype none

module ebc_bus_ctrl #(
    parameter int ADDR_W = 23,
    parameter int DATA_W = 16,
    parameter int WS_W = 3
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic rom_map_select_i,
    input wire logic output_disable_n_i,
    input wire logic bus_request_n_i,
    input wire logic ready_i,
    input wire logic acc_req_i,
    input wire ebc_pkg::ebc_space_t acc_space_i,
    input wire logic acc_write_i,
    input wire logic [ADDR_W-1:0] acc_addr_i,
    input wire logic [DATA_W-1:0] acc_wdata_i,
    input wire logic [WS_W-1:0] acc_wait_states_i,
    output logic acc_ready_o,
    output logic acc_done_o,
    output logic acc_internal_o,
    output logic [DATA_W-1:0] acc_rdata_o,
    input wire logic mode_wr_i,
    input wire logic mode_wdata_i,
    output logic microprocessor_mode_o,
    output logic data_space_sel_n_o,
    output logic program_space_sel_n_o,
    output logic io_space_sel_n_o,
    output logic space_sel_oe_o,
    output logic memory_strobe_n_o,
    output logic io_access_strobe_n_o,
    output logic strobe_oe_o,
    output logic read_write_o,
    output logic read_write_oe_o,
    output logic bus_grant_ack_n_o,
    output logic bus_grant_ack_oe_o,
    output logic [ADDR_W-1:0] external_address_lines_o,
    output logic external_address_oe_o,
    input wire logic [DATA_W-1:0] external_data_lines_i,
    output logic [DATA_W-1:0] external_data_lines_o,
    output logic external_data_oe_o
);
    import ebc_pkg::*;

    // ========================================================
    // elaboration checks
    if (ADDR_W < ROM_SEL_MSB + 1) begin : g_bad_addr_w
        $error("address width too small for the rom window");
    end
    if (WS_W < 2) begin : g_bad_ws_w
        $error("wait state count cannot reach the ready threshold");
    end

    // ========================================================
    // pin synchronisers
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [DATA_W-1:0] dsync1_reg;
    logic [DATA_W-1:0] dsync2_reg;
    logic [1:0] rom_sync_reg;
    logic rom_pin_s;
    logic off_n_s;
    logic hold_req_s;
    logic ready_s;

    // read data travels the same two stages as ready
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_reg <= SYNC_RESET;
            sync2_reg <= SYNC_RESET;
            dsync1_reg <= '0;
            dsync2_reg <= '0;
        end else begin
            sync1_reg <= {ready_i, bus_request_n_i, output_disable_n_i,
                          rom_map_select_i};
            sync2_reg <= sync1_reg;
            dsync1_reg <= external_data_lines_i;
            dsync2_reg <= dsync1_reg;
        end
    end

    // unreset, so the level held during reset is through when reset lifts
    always_ff @(posedge clk_i) begin
        rom_sync_reg <= {rom_sync_reg[0], rom_map_select_i};
    end

    assign rom_pin_s = rom_sync_reg[1];
    assign off_n_s = sync2_reg[SYNC_OFF_N];
    assign hold_req_s = !sync2_reg[SYNC_REQ_N];
    assign ready_s = sync2_reg[SYNC_READY];

    // ========================================================
    // rom map mode
    logic boot_done_reg;
    logic mode_reg;
    logic rom_hit;

    // the pin is caught in the first cycle after release, never later
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            boot_done_reg <= 1'b0;
        end else begin
            boot_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_reg <= MODE_MICROCOMPUTER;
        end else if (!boot_done_reg) begin
            mode_reg <= rom_pin_s; // R1 R2 R3
        end else if (mode_wr_i) begin
            mode_reg <= mode_wdata_i; // R3
        end
    end

    assign microprocessor_mode_o = mode_reg;
    assign rom_hit = (mode_reg == MODE_MICROCOMPUTER)
        && (acc_space_i == SPACE_PROG)
        && (acc_addr_i[ROM_SEL_MSB:ROM_SEL_LSB] == ROM_SEL_VAL); // R1 R2

    // ========================================================
    // access sequencer
    ebc_state_e state_reg;
    ebc_state_e state_next;
    logic take;
    logic ready_chk_reg;
    logic [WS_W-1:0] ws_cnt_reg;
    logic finish;

    // hold wins over a new access; a running access is never cut short
    assign acc_ready_o = (state_reg == ST_IDLE) && boot_done_reg
        && !hold_req_s;
    assign take = acc_req_i && acc_ready_o;
    assign finish = (state_reg == ST_ACCESS) && (ws_cnt_reg == '0)
        && (!ready_chk_reg || ready_s); // R9 R10 R11

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (boot_done_reg && hold_req_s) begin
                    state_next = ST_HOLD; // R16 R21
                end else if (take && !rom_hit) begin
                    state_next = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (finish) begin
                    state_next = ST_IDLE; // R21
                end
            end
            ST_HOLD: begin
                if (!hold_req_s) begin
                    state_next = ST_IDLE; // R21
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ws_cnt_reg <= '0;
            ready_chk_reg <= 1'b0;
        end else if (take && !rom_hit) begin
            // reads last the synchroniser depth so data is from this access
            ws_cnt_reg <= (!acc_write_i && 32'(acc_wait_states_i)
                < READY_MIN_WS) ? WS_W'(READY_MIN_WS) : acc_wait_states_i;
            ready_chk_reg <= (32'(acc_wait_states_i) >= READY_MIN_WS); // R10
        end else if (state_reg == ST_ACCESS && ws_cnt_reg != '0) begin
            ws_cnt_reg <= ws_cnt_reg - 1'b1; // R11
        end
    end

    // ========================================================
    // latched access attributes
    ebc_space_t space_reg;
    logic write_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            space_reg <= SPACE_DATA;
            write_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= '0;
        end else if (take && !rom_hit) begin
            space_reg <= acc_space_i;
            write_reg <= acc_write_i;
            addr_reg <= acc_addr_i;
            wdata_reg <= acc_wdata_i;
        end
    end

    // ========================================================
    // completion to the core
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_done_o <= 1'b0;
            acc_internal_o <= 1'b0;
            acc_rdata_o <= '0;
        end else begin
            acc_done_o <= finish || (take && rom_hit);
            acc_internal_o <= take && rom_hit;
            if (finish && !write_reg) begin
                acc_rdata_o <= dsync2_reg;
            end
        end
    end

    // ========================================================
    // pin drive
    logic in_access;
    logic drive_en;

    assign in_access = (state_reg == ST_ACCESS);
    // hold and output disable both release the selects, strobes, read/write and address pins
    assign drive_en = (state_reg != ST_HOLD) && off_n_s;

    assign data_space_sel_n_o = !(in_access && space_reg == SPACE_DATA); // R4
    assign program_space_sel_n_o = !(in_access && space_reg == SPACE_PROG);
    assign io_space_sel_n_o = !(in_access && space_reg == SPACE_IO); // R4
    assign space_sel_oe_o = drive_en; // R5

    assign memory_strobe_n_o = !(in_access && space_reg != SPACE_IO); // R6
    assign io_access_strobe_n_o = !(in_access && space_reg == SPACE_IO); // R7
    assign strobe_oe_o = drive_en; // R8

    assign read_write_o = !(in_access && write_reg); // R13
    assign read_write_oe_o = drive_en; // R14

    assign bus_grant_ack_n_o = (state_reg != ST_HOLD); // R16 R17
    assign bus_grant_ack_oe_o = off_n_s; // R18

    assign external_address_lines_o = addr_reg;
    assign external_address_oe_o = drive_en; // R19

    assign external_data_lines_o = wdata_reg;
    // a write overlapped by a bus request still completes, but undriven
    assign external_data_oe_o = in_access && write_reg && drive_en
        && !hold_req_s; // R20

    // ========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_ready_due;
        in_access && ws_cnt_reg == '0 && ready_chk_reg;
    endsequence
    sequence s_wait_running;
        in_access && ws_cnt_reg != '0;
    endsequence

    a_mode_change_cause: assert property ( // R3
        $changed(mode_reg) |-> $past(mode_wr_i) || !$past(boot_done_reg))
        else $error("mode changed without reset capture or write");
    a_one_space_low: assert property ( // R4
        in_access |-> $countones({data_space_sel_n_o,
            program_space_sel_n_o, io_space_sel_n_o}) == 2)
        else $error("not exactly one space select low");
    a_idle_lines_high: assert property ( // R6
        !in_access |-> data_space_sel_n_o && program_space_sel_n_o
            && io_space_sel_n_o && memory_strobe_n_o
            && io_access_strobe_n_o && read_write_o)
        else $error("control line active outside an access");
    a_strobe_by_space: assert property ( // R7
        in_access |-> (io_access_strobe_n_o == (space_reg != SPACE_IO))
            && (memory_strobe_n_o != io_access_strobe_n_o))
        else $error("strobe does not match space");
    a_hold_floats: assert property ( // R16
        state_reg == ST_HOLD |-> !space_sel_oe_o && !strobe_oe_o
            && !read_write_oe_o && !external_address_oe_o
            && !external_data_oe_o && !bus_grant_ack_n_o)
        else $error("lines driven while in hold");
    a_off_floats: assert property ( // R18
        !off_n_s |-> !space_sel_oe_o && !strobe_oe_o && !read_write_oe_o
            && !bus_grant_ack_oe_o && !external_address_oe_o)
        else $error("lines driven while output disable low");
    a_ready_retry: assert property ( // R9
        s_ready_due ##0 !ready_s |=> in_access [*1] ##0 !acc_done_o)
        else $error("access ended with ready low");
    a_no_early_ready: assert property ( // R11
        s_wait_running |=> in_access)
        else $error("access ended before wait states elapsed");
    a_ready_ignored: assert property ( // R10
        in_access && ws_cnt_reg == '0 && !ready_chk_reg
            |=> state_reg == ST_IDLE ##0 acc_done_o)
        else $error("ready waited on with few wait states");
    a_hold_grant: assert property ( // R21
        state_reg == ST_IDLE && boot_done_reg && hold_req_s
            |=> !bus_grant_ack_n_o)
        else $error("bus request not granted from idle");
    a_hold_release: assert property ( // R21
        state_reg == ST_HOLD && !hold_req_s
            |=> bus_grant_ack_n_o && external_address_oe_o == off_n_s)
        else $error("acknowledge kept after request removed");
    a_data_float: assert property ( // R20
        hold_req_s || !write_reg || !in_access |-> !external_data_oe_o)
        else $error("data driven outside a write or during request");

endmodule

`default_nettype wire

// ---- verilog/ebc_pkg.sv ----
`default_nettype none

package ebc_pkg;

    // ========================================================
    // address spaces
    typedef logic [1:0] ebc_space_t;
    localparam ebc_space_t SPACE_DATA = 2'h0;
    localparam ebc_space_t SPACE_PROG = 2'h1;
    localparam ebc_space_t SPACE_IO = 2'h2;

    // ========================================================
    // bus sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ACCESS = 3'h2,
        ST_HOLD = 3'h4
    } ebc_state_e;

    // ========================================================
    // ready qualification and rom map
    localparam int READY_MIN_WS = 2;
    localparam int ROM_SIZE_KWORDS = 16;
    localparam int ROM_SEL_MSB = 15;
    localparam int ROM_SEL_LSB = 14;
    localparam logic [1:0] ROM_SEL_VAL = 2'h3;
    localparam logic MODE_MICROCOMPUTER = 1'b0;
    localparam logic MODE_MICROPROCESSOR = 1'b1;

    // ========================================================
    // synchroniser bit positions and idle pin levels
    localparam int SYNC_W = 4;
    localparam int SYNC_ROM = 0;
    localparam int SYNC_OFF_N = 1;
    localparam int SYNC_REQ_N = 2;
    localparam int SYNC_READY = 3;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 4'h6;

endpackage

`default_nettype wire

// ---- testbench/ebc_ext_mem.sv ----
`timescale 1ns/100ps
`default_nettype none

// ========================================
// external memory and io device model
module ebc_ext_mem (
    input wire logic clk_i,
    input wire logic strobe_n_i,
    input wire logic read_write_i,
    input wire logic [22:0] addr_i,
    input wire logic [15:0] data_i,
    input wire logic [3:0] stall_i,
    output logic ready_o,
    output logic [15:0] data_o,
    output logic [15:0] wr_data_o
);
    logic [3:0] cnt_reg = 4'h0;
    logic [15:0] last_reg = 16'h0;

    always_ff @(posedge clk_i) begin
        if (strobe_n_i) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'hf) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    // not ready until the stall count has run out
    assign ready_o = !strobe_n_i && (cnt_reg >= stall_i);
    // released bus shows the inverse of the last value, never a stale match
    assign data_o = (!strobe_n_i && read_write_i) ?
        (addr_i[15:0] ^ 16'hc3c3) : ~last_reg;

    always_ff @(posedge clk_i) begin
        last_reg <= data_o;
        if (!strobe_n_i && !read_write_i) begin
            wr_data_o <= data_i;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import ebc_pkg::*;
    logic clk_i = 0, arst_n_i = 0, rom_map_select_i = 0;
    logic output_disable_n_i = 1, bus_request_n_i = 1, acc_req_i = 0;
    logic acc_write_i = 0, mode_wr_i = 0, mode_wdata_i = 0, ready_i;
    ebc_space_t acc_space_i = SPACE_DATA;
    logic [22:0] acc_addr_i = 0, external_address_lines_o;
    logic [15:0] acc_wdata_i = 0, acc_rdata_o, external_data_lines_i;
    logic [15:0] external_data_lines_o, mem_data, mem_wr;
    logic [2:0] acc_wait_states_i = 0;
    logic [3:0] stall = 0;
    logic acc_ready_o, acc_done_o, acc_internal_o, microprocessor_mode_o;
    logic data_space_sel_n_o, program_space_sel_n_o, io_space_sel_n_o;
    logic space_sel_oe_o, memory_strobe_n_o, io_access_strobe_n_o;
    logic strobe_oe_o, read_write_o, read_write_oe_o, bus_grant_ack_n_o;
    logic bus_grant_ack_oe_o, external_address_oe_o, external_data_oe_o;
    int failures = 0, samples_checked = 0;

    ebc_bus_ctrl u_dut (.clk_i, .arst_n_i, .rom_map_select_i,
        .output_disable_n_i, .bus_request_n_i, .ready_i, .acc_req_i,
        .acc_space_i, .acc_write_i, .acc_addr_i, .acc_wdata_i,
        .acc_wait_states_i, .acc_ready_o, .acc_done_o, .acc_internal_o,
        .acc_rdata_o, .mode_wr_i, .mode_wdata_i, .microprocessor_mode_o,
        .data_space_sel_n_o, .program_space_sel_n_o, .io_space_sel_n_o,
        .space_sel_oe_o, .memory_strobe_n_o, .io_access_strobe_n_o,
        .strobe_oe_o, .read_write_o, .read_write_oe_o, .bus_grant_ack_n_o,
        .bus_grant_ack_oe_o, .external_address_lines_o,
        .external_address_oe_o, .external_data_lines_i,
        .external_data_lines_o, .external_data_oe_o);

    ebc_ext_mem u_mem (.clk_i,
        .strobe_n_i((memory_strobe_n_o & io_access_strobe_n_o) | ~strobe_oe_o),
        .read_write_i(read_write_o), .addr_i(external_address_lines_o),
        .data_i(external_data_lines_i), .stall_i(stall), .ready_o(ready_i),
        .data_o(mem_data), .wr_data_o(mem_wr));

    assign external_data_lines_i = external_data_oe_o ?
        external_data_lines_o : mem_data;

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic complete_run;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask

    task automatic do_reset(input logic rom);
        @(negedge clk_i);
        arst_n_i = 0;
        rom_map_select_i = rom;
        cyc(2);
        chk(bus_grant_ack_n_o, 1);
        chk({data_space_sel_n_o, program_space_sel_n_o, io_space_sel_n_o,
            memory_strobe_n_o, io_access_strobe_n_o, read_write_o},
            6'h3f);
        cyc(10);
        arst_n_i = 1;
        cyc(3);
    endtask

    // seen: data oe, internal, rw low, io, mem, is, ps, ds
    task automatic access(input ebc_space_t sp, input logic wr,
        input logic [22:0] a, input logic [2:0] ws, output int n,
        output logic [7:0] s);
        n = 0;
        s = 0;
        @(negedge clk_i);
        acc_space_i = sp;
        acc_write_i = wr;
        acc_addr_i = a;
        acc_wdata_i = a[15:0] ^ 16'h5a5a;
        acc_wait_states_i = ws;
        while (acc_ready_o !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        if (n >= 50) begin
            failures++;
            complete_run();
        end
        n = 0;
        acc_req_i = 1;
        while (acc_done_o !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
            acc_req_i = 0;
            s = s | {external_data_oe_o, acc_internal_o & acc_done_o,
                ~read_write_o, ~io_access_strobe_n_o, ~memory_strobe_n_o,
                ~io_space_sel_n_o, ~program_space_sel_n_o,
                ~data_space_sel_n_o};
        end
        if (n >= 60) begin
            failures++;
            complete_run();
        end
    endtask

    task automatic wait_ack(input logic lvl);
        int k;
        for (k = 0; k < 20 && bus_grant_ack_n_o !== lvl; k++) begin
            cyc(1);
        end
        if (k >= 20) begin
            failures++;
            complete_run();
        end
    endtask

    task automatic t_mode;
        int n;
        logic [7:0] s;
        chk(microprocessor_mode_o, 0);
        access(SPACE_PROG, 0, 23'h00c123, 0, n, s);
        chk(s, 8'h40);
        @(negedge clk_i);
        mode_wr_i = 1;
        mode_wdata_i = 1;
        cyc(1);
        mode_wr_i = 0;
        cyc(1);
        chk(microprocessor_mode_o, 1);
        access(SPACE_PROG, 0, 23'h00c123, 0, n, s);
        chk(s, 8'h0a);
    endtask

    task automatic t_spaces;
        int n;
        logic [7:0] s;
        for (int i = 0; i < 3; i++) begin
            access(ebc_space_t'(i), 0, 23'h001234 + i, 0, n, s);
            chk(s, (8'h1 << i) | ((i == 2) ? 8'h10 : 8'h08));
            chk(acc_rdata_o, (16'h1234 + i) ^ 16'hc3c3);
        end
        access(SPACE_DATA, 1, 23'h000055, 0, n, s);
        chk(s, 8'ha9);
        chk(mem_wr, 16'h5a0f);
    endtask

    task automatic t_ready;
        int n0, n1, n2, n3;
        logic [7:0] s;
        stall = 8;
        access(SPACE_DATA, 0, 23'h000100, 1, n0, s);
        stall = 0;
        access(SPACE_DATA, 0, 23'h000100, 1, n1, s);
        chk(n0, n1);
        access(SPACE_DATA, 0, 23'h000100, 2, n2, s);
        access(SPACE_DATA, 0, 23'h000100, 3, n3, s);
        chk(n3, n2 + 1);
        stall = 8;
        access(SPACE_IO, 0, 23'h000100, 3, n0, s);
        chk(n0 > n3, 1);
    endtask

    task automatic t_hold;
        int n;
        logic [7:0] s;
        stall = 4;
        fork
            access(SPACE_DATA, 1, 23'h000200, 3, n, s);
            begin
                cyc(3);
                bus_request_n_i = 0;
            end
        join
        chk(bus_grant_ack_n_o, 1);
        wait_ack(0);
        chk({space_sel_oe_o, strobe_oe_o, read_write_oe_o,
            external_address_oe_o, external_data_oe_o},
            0);
        chk(acc_ready_o, 0);
        cyc(5);
        chk(bus_grant_ack_n_o, 0);
        bus_request_n_i = 1;
        wait_ack(1);
        chk({space_sel_oe_o, strobe_oe_o, read_write_oe_o,
            external_address_oe_o}, 4'hf);
    endtask

    task automatic t_off;
        @(negedge clk_i);
        output_disable_n_i = 0;
        cyc(4);
        chk({space_sel_oe_o, strobe_oe_o, read_write_oe_o,
            external_address_oe_o, bus_grant_ack_oe_o},
            0);
        output_disable_n_i = 1;
        cyc(4);
        chk({space_sel_oe_o, strobe_oe_o, bus_grant_ack_oe_o}, 3'h7);
    endtask

    // mid-run reset with the rom pin high: mode must follow the pin
    task automatic t_rom_pin;
        int n;
        logic [7:0] s;
        do_reset(1);
        chk(microprocessor_mode_o, 1);
        access(SPACE_PROG, 0, 23'h00c000, 0, n, s);
        chk(s, 8'h0a);
    endtask

    initial begin
        cyc(12);
        arst_n_i = 1;
        cyc(3);
        t_mode();
        t_spaces();
        t_ready();
        t_hold();
        t_off();
        t_rom_pin();
        complete_run();
    end
endmodule
`default_nettype wire
